// >>> design/msp_pkg.sv
package msp_pkg;

    // ------------------------------------------------------------------
    // Geometry of the process image
    // ------------------------------------------------------------------
    localparam int MOD_N = 12;                 // Expansion modules
    localparam int ELEM_W = 8;                 // Elements per value byte
    localparam int PAIR_N = 4;                 // Pairs per value byte
    localparam int IO_BITS = MOD_N * ELEM_W;
    localparam int PAIR_BITS = MOD_N * PAIR_N;
    localparam int CFG_W = PAIR_BITS;
    localparam int CTRL_BYTES = 10;
    localparam int CTRL_BITS = CTRL_BYTES * 8;
    localparam int IO_STAT_BITS = MOD_N * 32;
    localparam int SUM_W = 15;                 // Bit 15 is reserved
    localparam int COLL_BYTE = 2 * MOD_N;      // Collective state in set 1
    localparam int DS1_BYTES = 2 * MOD_N + 4;
    localparam int DS1_WORDS = DS1_BYTES / 4;
    localparam int DS3_BYTES = 60;
    localparam int DS3_WORDS = DS3_BYTES / 4;
    localparam int SNAP_W = 16;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] PAIR_IN_LO_ADDR = 12'h004;
    localparam logic [11:0] PAIR_IN_HI_ADDR = 12'h008;
    localparam logic [11:0] PAIR_OUT_LO_ADDR = 12'h00c;
    localparam logic [11:0] PAIR_OUT_HI_ADDR = 12'h010;
    localparam logic [11:0] IRQ_STAT_ADDR = 12'h014;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h018;
    localparam logic [11:0] FWD_TX_ADDR = 12'h01c;
    localparam logic [11:0] FWD_RX_ADDR = 12'h020;
    localparam logic [11:0] SNAP_CNT_ADDR = 12'h024;
    localparam logic [11:0] LIVE_SUM_ADDR = 12'h028;
    localparam logic [11:0] DS1_BASE = 12'h100;
    localparam logic [11:0] DS1_END = 12'h11c;
    localparam logic [11:0] DS3_BASE = 12'h200;
    localparam logic [11:0] DS3_END = 12'h23c;

    // ------------------------------------------------------------------
    // Fixed bits and reset values
    // ------------------------------------------------------------------
    localparam logic [CTRL_BITS-1:0] CTRL_RSVD_MASK =
        80'h0000_0000_0000_0000_3001;
    localparam logic [15:0] CTRL_RSVD_PAD = 16'hffff;
    localparam int CTRL_SUM_IN_BIT = 14;
    localparam int CTRL_SUM_OUT_BIT = 15;
    localparam logic [CFG_W-1:0] CFG_RST = 48'h0000_0000_0000;
    localparam logic FREEZE_RST = 1'h0;

    // Interrupt events
    localparam int EV_N = 3;
    localparam int EV_SNAP = 0;
    localparam int EV_ERR = 1;
    localparam int EV_FWD = 2;
    localparam logic [EV_N-1:0] MASK_RST = 3'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } msp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } msp_apb_rsp_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } msp_fwd_t;

endpackage

// >>> design/msp_pair_packer.sv
`timescale 1ns/1ns
module msp_pair_packer (
    input logic [7:0] raw,
    input logic [3:0] pair_ok,
    input logic [3:0] pair_cfg,
    input logic is_output,
    output logic [7:0] packed_byte
);
    import msp_pkg::*;

    // ------------------------------------------------------------------
    // Pair encoding of one value byte
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PAIR_N; p++) begin : g_pair
            // Lower bit passes the evaluated state or the command
            assign packed_byte[2*p] = raw[2*p];
            // Upper bit: single element, pair status, or forced low
            assign packed_byte[2*p+1] = !pair_cfg[p] ? raw[2*p+1] :
                (is_output ? 1'h0 : pair_ok[p]);
        end
    endgenerate

endmodule

// >>> design/msp_packer.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module msp_packer (
    input logic clk,
    input logic rst,
    input msp_pkg::msp_apb_req_t apb_req,
    output msp_pkg::msp_apb_rsp_t apb_rsp,
    output logic irq,
    input logic logic_cycle_done,
    input logic [msp_pkg::IO_BITS-1:0] in_elem,
    input logic [msp_pkg::PAIR_BITS-1:0] in_pair_ok,
    input logic [msp_pkg::IO_BITS-1:0] out_cmd,
    input logic [msp_pkg::MOD_N-1:0] mod_has_out,
    input logic [msp_pkg::CTRL_BITS-1:0] ctrl_stat,
    input logic [msp_pkg::IO_STAT_BITS-1:0] io_stat,
    input logic [msp_pkg::SUM_W-1:0] sum_in_ok,
    input logic [msp_pkg::SUM_W-1:0] sum_out_ok,
    input msp_pkg::msp_fwd_t fwd_rx,
    output msp_pkg::msp_fwd_t fwd_tx
);
    import msp_pkg::*;

    // ------------------------------------------------------------------
    // State of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic freeze;
        logic [CFG_W-1:0] in_cfg;
        logic [CFG_W-1:0] out_cfg;
        logic [EV_N-1:0] irq_stat;
        logic [EV_N-1:0] irq_mask;
        logic irq;
        logic [31:0] fwd_rx_data;
        logic [31:0] fwd_tx_data;
        logic fwd_tx_valid;
        logic [SNAP_W-1:0] snap_cnt;
        logic prev_all_ok;
        logic [DS1_WORDS*32-1:0] ds1;
        logic [DS3_WORDS*32-1:0] ds3;
    } msp_state_t;

    msp_state_t st;
    msp_state_t next_st;

    logic [DS1_WORDS*32-1:0] ds1_live;
    logic [DS3_WORDS*32-1:0] ds3_live;
    logic [IO_BITS-1:0] out_byte_raw;
    logic [CTRL_BITS-1:0] ctrl_fixed;
    logic all_ok;
    logic acc;
    logic [5:0] win_idx;
    logic [31:0] rd_word;
    logic map_hit;
    logic [EV_N-1:0] ev;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Byte-lane merge of a write into an old register value
    function automatic logic [31:0] msp_merge(
        input logic [31:0] old_val,
        input logic [31:0] wr_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wr_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Data set 1: value bytes per module
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < MOD_N; g++) begin : g_mod
            // Input value byte of module g+1
            msp_pair_packer u_in (
                .raw(in_elem[g*8 +: 8]),
                .pair_ok(in_pair_ok[g*4 +: 4]),
                .pair_cfg(st.in_cfg[g*4 +: 4]),
                .is_output(1'h0),
                .packed_byte(ds1_live[g*8 +: 8])
            );
            // Output value byte of module g+1
            msp_pair_packer u_out (
                .raw(out_cmd[g*8 +: 8]),
                .pair_ok(4'h0),
                .pair_cfg(st.out_cfg[g*4 +: 4]),
                .is_output(1'h1),
                .packed_byte(out_byte_raw[g*8 +: 8])
            );
            // Modules without outputs leave their byte at zero
            assign ds1_live[(MOD_N+g)*8 +: 8] =
                mod_has_out[g] ? out_byte_raw[g*8 +: 8] : 8'h00;
        end
    endgenerate

    // Collective state: input sums then output sums, two bytes each
    assign ds1_live[COLL_BYTE*8 +: 32] =
        {1'h1, sum_out_ok, 1'h1, sum_in_ok};

    // ------------------------------------------------------------------
    // Data set 3: fixed controller and module state
    // ------------------------------------------------------------------

    // Controller bytes with reserved bits high and sum bits folded in
    always_comb begin
        ctrl_fixed = ctrl_stat | CTRL_RSVD_MASK;
        ctrl_fixed[CTRL_SUM_IN_BIT] = &sum_in_ok;
        ctrl_fixed[CTRL_SUM_OUT_BIT] = &sum_out_ok;
    end

    // Ten controller bytes, two pad bytes, then one word per module
    assign ds3_live = {io_stat, CTRL_RSVD_PAD, ctrl_fixed};

    assign all_ok = (&sum_in_ok) & (&sum_out_ok);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign acc = apb_req.psel & apb_req.penable;
    assign win_idx = apb_req.paddr[7:2];

    // Read data and map check for the current address
    always_comb begin
        rd_word = 32'h0000_0000;
        map_hit = 1'h1;
        if (apb_req.paddr[1:0] != 2'h0) begin
            map_hit = 1'h0;
        end else if (apb_req.paddr == CTRL_ADDR) begin
            rd_word = {31'h0000_0000, st.freeze};
        end else if (apb_req.paddr == PAIR_IN_LO_ADDR) begin
            rd_word = st.in_cfg[31:0];
        end else if (apb_req.paddr == PAIR_IN_HI_ADDR) begin
            rd_word = {16'h0000, st.in_cfg[47:32]};
        end else if (apb_req.paddr == PAIR_OUT_LO_ADDR) begin
            rd_word = st.out_cfg[31:0];
        end else if (apb_req.paddr == PAIR_OUT_HI_ADDR) begin
            rd_word = {16'h0000, st.out_cfg[47:32]};
        end else if (apb_req.paddr == IRQ_STAT_ADDR) begin
            rd_word = {29'h0000_0000, st.irq_stat};
        end else if (apb_req.paddr == IRQ_MASK_ADDR) begin
            rd_word = {29'h0000_0000, st.irq_mask};
        end else if (apb_req.paddr == FWD_TX_ADDR) begin
            rd_word = st.fwd_tx_data;
        end else if (apb_req.paddr == FWD_RX_ADDR) begin
            rd_word = st.fwd_rx_data;
        end else if (apb_req.paddr == SNAP_CNT_ADDR) begin
            rd_word = {16'h0000, st.snap_cnt};
        end else if (apb_req.paddr == LIVE_SUM_ADDR) begin
            rd_word = {1'h1, sum_out_ok, 1'h1, sum_in_ok};
        end else if (apb_req.paddr >= DS1_BASE &&
                     apb_req.paddr < DS1_END) begin
            rd_word = st.ds1[win_idx*32 +: 32];
        end else if (apb_req.paddr >= DS3_BASE &&
                     apb_req.paddr < DS3_END) begin
            rd_word = st.ds3[(win_idx - 6'h00)*32 +: 32];
        end else begin
            map_hit = 1'h0;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        ev = '0;
        next_st.fwd_tx_valid = 1'h0;
        next_st.pready = 1'h0;
        next_st.pslverr = 1'h0;

        // Snapshot of both data sets at the logic cycle edge
        if (logic_cycle_done && !st.freeze) begin
            next_st.ds1 = ds1_live;
            next_st.ds3 = ds3_live;
            next_st.snap_cnt = st.snap_cnt + 16'h0001;
            next_st.prev_all_ok = all_ok;
            ev[EV_SNAP] = 1'h1;
            if (st.prev_all_ok && !all_ok) begin
                ev[EV_ERR] = 1'h1;
            end
        end

        // Word from the other gateway, kept for the local network
        if (fwd_rx.valid) begin
            next_st.fwd_rx_data = fwd_rx.data;
            ev[EV_FWD] = 1'h1;
        end

        // First access cycle: latch the answer, ready next cycle
        if (acc && !st.pready) begin
            next_st.pready = 1'h1;
            next_st.pslverr = ~map_hit;
            next_st.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_word;
        end

        // Completion edge: writes land, a status read clears what it saw
        if (acc && st.pready && !st.pslverr) begin
            if (!apb_req.pwrite) begin
                if (apb_req.paddr == IRQ_STAT_ADDR) begin
                    next_st.irq_stat = st.irq_stat & ~st.prdata[EV_N-1:0];
                end
            end else if (apb_req.paddr == CTRL_ADDR) begin
                if (apb_req.pstrb[0]) begin
                    next_st.freeze = apb_req.pwdata[0];
                end
            end else if (apb_req.paddr == PAIR_IN_LO_ADDR) begin
                next_st.in_cfg[31:0] = msp_merge(st.in_cfg[31:0],
                    apb_req.pwdata, apb_req.pstrb);
            end else if (apb_req.paddr == PAIR_IN_HI_ADDR) begin
                next_st.in_cfg[47:32] = msp_merge({16'h0000,
                    st.in_cfg[47:32]}, apb_req.pwdata, apb_req.pstrb)
                    [15:0];
            end else if (apb_req.paddr == PAIR_OUT_LO_ADDR) begin
                next_st.out_cfg[31:0] = msp_merge(st.out_cfg[31:0],
                    apb_req.pwdata, apb_req.pstrb);
            end else if (apb_req.paddr == PAIR_OUT_HI_ADDR) begin
                next_st.out_cfg[47:32] = msp_merge({16'h0000,
                    st.out_cfg[47:32]}, apb_req.pwdata, apb_req.pstrb)
                    [15:0];
            end else if (apb_req.paddr == IRQ_MASK_ADDR) begin
                next_st.irq_mask = msp_merge({29'h0000_0000, st.irq_mask},
                    apb_req.pwdata, apb_req.pstrb)[EV_N-1:0];
            end else if (apb_req.paddr == FWD_TX_ADDR) begin
                next_st.fwd_tx_data = msp_merge(st.fwd_tx_data,
                    apb_req.pwdata, apb_req.pstrb);
                next_st.fwd_tx_valid = 1'h1;
            end
        end

        // New events win over a clear in the same cycle
        next_st.irq_stat = next_st.irq_stat | ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st.prdata <= 32'h0000_0000;
            st.pready <= 1'h0;
            st.pslverr <= 1'h0;
            st.freeze <= FREEZE_RST;
            st.in_cfg <= CFG_RST;
            st.out_cfg <= CFG_RST;
            st.irq_stat <= '0;
            st.irq_mask <= MASK_RST;
            st.irq <= 1'h0;
            st.fwd_rx_data <= 32'h0000_0000;
            st.fwd_tx_data <= 32'h0000_0000;
            st.fwd_tx_valid <= 1'h0;
            st.snap_cnt <= '0;
            st.prev_all_ok <= 1'h1;
            st.ds1 <= '0;
            st.ds3 <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------
    assign apb_rsp.prdata = st.prdata;
    assign apb_rsp.pready = st.pready;
    assign apb_rsp.pslverr = st.pslverr;
    assign irq = st.irq;
    assign fwd_tx.valid = st.fwd_tx_valid;
    assign fwd_tx.data = st.fwd_tx_data;

endmodule

// >>> sim/msp_packer_properties.sv
`timescale 1ns/1ns
module msp_packer_checker (
    input logic clk,
    input logic rst,
    input msp_pkg::msp_apb_req_t apb_req,
    input msp_pkg::msp_apb_rsp_t apb_rsp,
    input logic irq,
    input logic logic_cycle_done,
    input logic [msp_pkg::SUM_W-1:0] sum_in_ok,
    input logic [msp_pkg::SUM_W-1:0] sum_out_ok,
    input msp_pkg::msp_fwd_t fwd_rx,
    input msp_pkg::msp_fwd_t fwd_tx
);
    import msp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic acc;
    logic rd_ok;
    // Access phase and a good read completing
    assign acc = apb_req.psel && apb_req.penable;
    assign rd_ok = acc && apb_rsp.pready && !apb_req.pwrite
        && !apb_rsp.pslverr;
    // --------------------------------------------------------------
    // Bus, forwarding, fixed-bit and interrupt checks
    // --------------------------------------------------------------
    ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready stood longer than one cycle");
    ready_wait_a: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready did not follow the first access cycle");
    err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    misalign_err_a: assert property (acc && apb_rsp.pready
        && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr)
        else $error("misaligned access not refused");
    fwd_pulse_a: assert property (fwd_tx.valid |=> !fwd_tx.valid)
        else $error("forward valid longer than one cycle");
    fwd_cause_a: assert property (fwd_tx.valid |->
        $past(acc && apb_rsp.pready
        && apb_req.pwrite && apb_req.paddr == FWD_TX_ADDR)
        && fwd_tx.data == $past(apb_req.pwdata))
        else $error("forward word without matching write");
    live_sum_a: assert property (rd_ok &&
        apb_req.paddr == LIVE_SUM_ADDR
        |-> apb_rsp.prdata == {1'b1, $past(sum_out_ok), 1'b1,
        $past(sum_in_ok)})
        else $error("live sum word wrong");
    ctrl_rsvd_a: assert property (rd_ok &&
        apb_req.paddr == DS3_BASE
        |-> apb_rsp.prdata[0] && apb_rsp.prdata[13:12] == 2'h3)
        else $error("reserved controller bits not one");
    pad_ones_a: assert property (rd_ok &&
        apb_req.paddr == DS3_BASE + 12'h8
        |-> apb_rsp.prdata[31:16] == 16'hffff)
        else $error("reserved controller bytes not one");
    irq_rise_a: assert property ($rose(irq) |-> $past(logic_cycle_done
        || fwd_rx.valid || (acc && apb_req.pwrite)))
        else $error("interrupt rose without an event");
    irq_fall_a: assert property ($fell(irq) |-> $past(acc && apb_rsp.pready))
        else $error("interrupt fell without a bus access");
    cover property (fwd_tx.valid);
    cover property (rd_ok && apb_req.paddr == DS3_BASE);
    cover property ($rose(irq));
endmodule
bind msp_packer msp_packer_checker chk (.clk(clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq),
    .logic_cycle_done(logic_cycle_done), .sum_in_ok(sum_in_ok),
    .sum_out_ok(sum_out_ok), .fwd_rx(fwd_rx), .fwd_tx(fwd_tx));

// >>> sim/msp_peer_gateway.sv
`timescale 1ns/1ns
module msp_peer_gateway (
    input logic clk,
    input logic rst,
    input logic [7:0] lat,
    input msp_pkg::msp_fwd_t fwd_tx,
    output msp_pkg::msp_fwd_t fwd_rx
);
    import msp_pkg::*;
    logic [7:0] cnt;
    logic [31:0] held;
    // Return each word inverted after lat cycles; idle data toggles
    always_ff @(posedge clk) begin
        fwd_rx.valid <= 1'b0;
        fwd_rx.data <= ~fwd_rx.data;
        if (rst) begin
            cnt <= 8'h0;
            fwd_rx <= '0;
        end else if (fwd_tx.valid) begin
            cnt <= lat;
            held <= ~fwd_tx.data;
        end else if (cnt == 8'h1) begin
            cnt <= 8'h0;
            fwd_rx.valid <= 1'b1;
            fwd_rx.data <= held;
        end else if (cnt != 8'h0) begin
            cnt <= cnt - 8'h1;
        end
    end
endmodule

// >>> sim/module_status_packer_bench.sv
`timescale 1ns/1ns
module module_status_packer_bench;
    import msp_pkg::*;
    localparam logic [47:0] CIN = 48'h3c96_a5c3_0f69;
    localparam logic [47:0] COUT = 48'hc369_5a3c_f096;
    logic clk, rst, lcd, irq, err;
    msp_apb_req_t req;
    msp_apb_rsp_t rsp;
    logic [IO_BITS-1:0] in_elem, out_cmd;
    logic [PAIR_BITS-1:0] pair_ok;
    logic [MOD_N-1:0] has_out;
    logic [CTRL_BITS-1:0] ctrl_stat;
    logic [IO_STAT_BITS-1:0] io_stat;
    logic [SUM_W-1:0] sin, sout;
    msp_fwd_t frx, ftx;
    logic [7:0] lat;
    logic [31:0] rd;
    logic [7:0] e1 [DS1_BYTES];
    logic [7:0] e3 [DS3_BYTES];
    int n_mismatch, comparisons, cycles;
    msp_packer uut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .irq(irq), .logic_cycle_done(lcd), .in_elem(in_elem),
        .in_pair_ok(pair_ok), .out_cmd(out_cmd), .mod_has_out(has_out),
        .ctrl_stat(ctrl_stat), .io_stat(io_stat), .sum_in_ok(sin),
        .sum_out_ok(sout), .fwd_rx(frx), .fwd_tx(ftx));
    msp_peer_gateway peer (.clk(clk), .rst(rst), .lat(lat), .fwd_tx(ftx),
        .fwd_rx(frx));
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task end_sim;
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; held until pready is sampled high
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        req.pstrb <= 4'hf;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task snap;
        lcd <= 1'b1;
        @(posedge clk);
        lcd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Pair encoding: odd bit is status on inputs, low on outputs
    function automatic logic [7:0] pk(input logic [7:0] r,
        input logic [3:0] ok, input logic [3:0] c, input logic o);
        logic [7:0] b;
        b = r;
        for (int p = 0; p < 4; p++)
            if (c[p]) b[2*p+1] = o ? 1'b0 : ok[p];
        return b;
    endfunction
    task calc1;
        for (int m = 0; m < MOD_N; m++) begin
            e1[m] = pk(in_elem[8*m+:8], pair_ok[4*m+:4], CIN[4*m+:4], 1'b0);
            e1[12+m] = has_out[m] ? pk(out_cmd[8*m+:8], 4'h0, COUT[4*m+:4],
                1'b1) : 8'h00;
        end
        {e1[25], e1[24]} = {1'b1, sin};
        {e1[27], e1[26]} = {1'b1, sout};
    endtask
    task ds1chk;
        for (int w = 0; w < DS1_WORDS; w++)
            rdchk(DS1_BASE + 12'(4*w), {e1[4*w+3], e1[4*w+2], e1[4*w+1],
                e1[4*w]});
    endtask
    // --------------------------------------------------------------
    // Clock, watchdog and test sequence
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            end_sim;
        end
    end
    initial begin
        rst = 1'b1;
        lcd = 1'b0;
        req = '0;
        lat = 8'h1;
        has_out = 12'ha5f;
        sin = '1;
        sout = 15'h7ffe;
        for (int m = 0; m < MOD_N; m++) begin
            in_elem[8*m+:8] = 8'(m * 37 + 5);
            out_cmd[8*m+:8] = 8'(m * 53 + 9);
            pair_ok[4*m+:4] = 4'(m);
            io_stat[32*m+:32] = 32'h0403_0201 + 32'(m) * 32'h1111_1111;
        end
        for (int k = 0; k < CTRL_BYTES; k++) ctrl_stat[8*k+:8] = 8'(k * 29);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(DS1_BASE, 32'h0);
        rdchk(SNAP_CNT_ADDR, 32'h0);
        xfer(1'b1, PAIR_IN_LO_ADDR, CIN[31:0]);
        xfer(1'b1, PAIR_IN_HI_ADDR, {16'h0, CIN[47:32]});
        xfer(1'b1, PAIR_OUT_LO_ADDR, COUT[31:0]);
        xfer(1'b1, PAIR_OUT_HI_ADDR, {16'h0, COUT[47:32]});
        snap();
        calc1();
        ds1chk();
        rdchk(SNAP_CNT_ADDR, 32'h1);
        // Frozen: changed inputs and a cycle end leave set 1 alone
        xfer(1'b1, CTRL_ADDR, 32'h1);
        in_elem <= ~in_elem;
        snap();
        ds1chk();
        xfer(1'b1, CTRL_ADDR, 32'h0);
        snap();
        calc1();
        ds1chk();
        // Set 3: controller bytes, padding, module words
        for (int k = 0; k < CTRL_BYTES; k++) e3[k] = ctrl_stat[8*k+:8];
        e3[0][0] = 1'b1;
        e3[1][7:4] = {&sout, &sin, 2'b11};
        e3[10] = 8'hff;
        e3[11] = 8'hff;
        for (int m = 0; m < MOD_N; m++)
            for (int b = 0; b < 4; b++) e3[12+4*m+b] = io_stat[32*m+8*b+:8];
        xfer(1'b1, DS3_BASE, 32'h0);
        for (int w = 0; w < DS3_WORDS; w++)
            rdchk(DS3_BASE + 12'(4*w), {e3[4*w+3], e3[4*w+2], e3[4*w+1],
                e3[4*w]});
        rdchk(LIVE_SUM_ADDR, {1'b1, sout, 1'b1, sin});
        // Interrupts: snapshot, collective drop, masking, read clear
        xfer(1'b0, IRQ_STAT_ADDR, 32'h0);
        xfer(1'b1, IRQ_MASK_ADDR, 32'h1);
        snap();
        check({31'h0, irq}, 32'h1);
        rdchk(IRQ_STAT_ADDR, 32'h1);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, IRQ_MASK_ADDR, 32'h2);
        sout <= '1;
        snap();
        xfer(1'b0, IRQ_STAT_ADDR, 32'h0);
        sout <= 15'h7ffe;
        snap();
        check({31'h0, irq}, 32'h1);
        rdchk(IRQ_STAT_ADDR, 32'h3);
        // Forwarding with a prompt and a slow peer
        for (int i = 0; i < 2; i++) begin
            lat <= i ? 8'h14 : 8'h1;
            xfer(1'b1, FWD_TX_ADDR, 32'hc0de_1234 + 32'(i));
            while (frx.valid !== 1'b1) @(posedge clk);
            @(posedge clk);
            rdchk(FWD_RX_ADDR, ~(32'hc0de_1234 + 32'(i)));
            rdchk(IRQ_STAT_ADDR, 32'h4);
        end
        // Unmapped and misaligned accesses are refused
        xfer(1'b0, 12'h300, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        xfer(1'b0, DS1_BASE + 12'h2, 32'h0);
        check({31'h0, err}, 32'h1);
        end_sim;
    end
endmodule
